// ===== design/teq_defs.svh
// constants of the tape equalizer mode and search control block
// assumes a single 50 MHz system clock and a byte-wide register port
`ifndef TEQ_DEFS_SVH
`define TEQ_DEFS_SVH

// timing
`define TEQ_CLK_HZ 50000000
// 96 kbit/s per data track, ten slots per frame
`define TEQ_SLOT_RATE_HZ 960000
`define TEQ_STEP_HALF (`TEQ_CLK_HZ / (2 * `TEQ_SLOT_RATE_HZ))
`define TEQ_QUAL_US 1000
`define TEQ_QUAL_CYCLES (`TEQ_QUAL_US * (`TEQ_CLK_HZ / 1000000))
`define TEQ_TICK_US 100
`define TEQ_TICK_CYCLES (`TEQ_TICK_US * (`TEQ_CLK_HZ / 1000000))

// frame layout
`define TEQ_SLOT_LAST 4'h9
`define TEQ_SLOT_SPARE 4'h8
`define TEQ_SLOT_AUX 4'h9
`define TEQ_CHAN_AUX 4'h8
`define TEQ_UPSAMPLE 4'hA

// register offsets
`define TEQ_ADDR_MODE 2'h0
`define TEQ_ADDR_SPEED 2'h1
`define TEQ_ADDR_STATUS 2'h2
`define TEQ_ADDR_EYE 2'h3

// reset values and fixed levels
`define TEQ_RST_MODE 2'h3
`define TEQ_RST_XFER 2'h1
`define TEQ_RST_SPEED 8'h80
`define TEQ_RST_EYE_AN 8'hFF
`define TEQ_ALL_OFF 9'h1FF
`define TEQ_ENV_THRESH 8'h20
`define TEQ_TICK_SAT 6'h20

`endif

// ===== design/teq_pkg.sv
// types of the tape equalizer mode and search control block
// assumes teq_defs.svh is on the include path
`include "teq_defs.svh"

package teq_pkg;

    // operation mode as carried in the mode settings byte
    typedef enum logic [1:0] {
        TEQ_NORMAL = 2'b00,
        TEQ_TEST   = 2'b01,
        TEQ_SEARCH = 2'b10,
        TEQ_OFF    = 2'b11
    } teq_mode_t;

    typedef enum logic [1:0] {
        TEQ_EYE_IDLE  = 2'b00,
        TEQ_EYE_SHIFT = 2'b01,
        TEQ_EYE_LAST  = 2'b11
    } teq_eye_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } teq_bus_req_t;

    typedef struct packed {
        teq_mode_t mode;
        logic [1:0] xfer;
        logic [3:0] eye_sel;
        logic [4:0] div_cnt;
        logic step_int;
        logic [3:0] slot;
        logic [8:0][7:0] cur;
        logic [8:0][7:0] prev;
        logic [8:0] sliced;
        logic out_step;
        logic out_sync;
        logic [8:0] oe_n;
        teq_eye_t eye_st;
        logic [7:0] eye_sh;
        logic [2:0] eye_cnt;
        logic eye_ser;
        logic eye_val;
        logic [7:0] eye_an;
        logic env_cand;
        logic env;
        logic env_out;
        logic [15:0] hi_cnt;
        logic [15:0] lo_cnt;
        logic label;
        logic blank;
        logic [15:0] tick_cnt;
        logic [5:0] ticks;
        logic [7:0] spd;
        logic [7:0] rdata;
    } teq_state_t;

endpackage

// ===== design/teq_top.sv
// tape equalizer mode, read amplifier timing, eye output and search detection
// assumes converter samples arrive on clk; host reaches registers over a plain port
`include "teq_defs.svh"
module teq_top
    import teq_pkg::*;
#(
    parameter int QUAL_CYCLES = `TEQ_QUAL_CYCLES,
    parameter int TICK_CYCLES = `TEQ_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire teq_pkg::teq_bus_req_t bus,
    output logic [7:0] rdata,
    // converter sample of the multiplexed analog input
    input wire logic [7:0] multiplexed_analog_in,
    // read amplifier timing
    output logic mux_step_clock,
    output logic mux_frame_sync,
    // sliced tracks, index 0 is the first track, 7 the last, 8 aux
    output logic [7:0] track_out,
    output logic aux_out,
    output logic [8:0] track_oe_n,
    // eye outputs
    output logic digital_eye_serial,
    output logic eye_bit_valid,
    output logic [7:0] analog_eye_out,
    // search outputs
    output logic sliced_envelope_out,
    output logic label_detect,
    output logic blank_detect
);
    import teq_pkg::*;

    localparam logic [4:0] HALF_LAST = 5'(`TEQ_STEP_HALF - 1);
    localparam logic [15:0] QUAL = 16'(QUAL_CYCLES);
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

    teq_state_t st;
    teq_state_t next_st;
    logic [8:0] slice_now;
    logic [3:0] w_new;
    logic [3:0] w_old;

    // one interpolation phase per slot gives the ten-fold up-sampling per frame
    assign w_new = st.slot;
    assign w_old = `TEQ_UPSAMPLE - st.slot;

    for (genvar g = 0; g < 9; g++) begin : g_slice
        logic signed [13:0] mix;
        assign mix = 14'($signed(st.prev[g])) * 14'($signed({1'b0, w_old}))
                   + 14'($signed(st.cur[g])) * 14'($signed({1'b0, w_new}));
        assign slice_now[g] = ~mix[13];
    end

    // range is the largest shift that keeps the count within five bits
    function automatic logic [7:0] speed_code(input logic [5:0] t);
        logic [7:0] r;
        r = `TEQ_RST_SPEED;
        if (t >= `TEQ_TICK_SAT) begin
            r = `TEQ_RST_SPEED;
        end else if (t <= 6'h03) begin
            r = {1'b0, t[1:0], 3'h0, 2'h3};
        end else if (t <= 6'h07) begin
            r = {1'b0, t[2:0], 2'h0, 2'h2};
        end else if (t <= 6'h0F) begin
            r = {1'b0, t[3:0], 1'b0, 2'h1};
        end else begin
            r = {1'b0, t[4:0], 2'h0};
        end
        return r;
    endfunction

    always_comb begin
        logic rise;
        logic fall;
        logic [3:0] idx;
        logic [3:0] eye_slot;
        logic [7:0] mag;
        logic raw;
        logic [7:0] ob;
        rise = 1'b0;
        fall = 1'b0;
        idx = 4'h0;
        eye_slot = 4'h0;
        mag = 8'h00;
        raw = 1'b0;
        ob = {~multiplexed_analog_in[7], multiplexed_analog_in[6:0]};
        next_st = st;

        // register port, answer one cycle after the strobe
        next_st.rdata = 8'h00;
        if (bus.wr) begin
            if (bus.addr == `TEQ_ADDR_MODE) begin
                next_st.mode = teq_mode_t'(bus.wdata[1:0]);
                next_st.xfer = bus.wdata[3:2];
            end else if (bus.addr == `TEQ_ADDR_EYE) begin
                next_st.eye_sel = bus.wdata[3:0];
            end
        end
        if (bus.rd) begin
            if (bus.addr == `TEQ_ADDR_MODE) begin
                next_st.rdata = {4'h0, st.xfer, st.mode};
            end else if (bus.addr == `TEQ_ADDR_SPEED) begin
                next_st.rdata = st.spd;
            end else if (bus.addr == `TEQ_ADDR_STATUS) begin
                next_st.rdata = {5'h00, st.blank, st.label, st.env_out};
            end else if (bus.addr == `TEQ_ADDR_EYE) begin
                next_st.rdata = {4'h0, st.eye_sel};
            end
        end

        // fixed divider off the single clock
        if (st.div_cnt == HALF_LAST) begin
            next_st.div_cnt = 5'h00;
            next_st.step_int = ~st.step_int;
            rise = ~st.step_int;
            fall = st.step_int;
        end else begin
            next_st.div_cnt = st.div_cnt + 5'h01;
        end
        // slot advances on each rising step edge
        if (rise) begin
            next_st.slot = (st.slot == `TEQ_SLOT_LAST) ? 4'h0 : st.slot + 4'h1;
            if (st.mode == TEQ_NORMAL || st.mode == TEQ_TEST) begin
                // all nine tracks refresh their sliced level
                next_st.sliced = slice_now;
            end
        end

        // sample mid-slot when the amplifier output has settled
        idx = (st.slot == `TEQ_SLOT_AUX) ? `TEQ_CHAN_AUX : st.slot;
        // search input carries only the aux signal
        if (st.mode == TEQ_SEARCH) begin
            idx = `TEQ_CHAN_AUX;
        end
        if (fall && (st.mode == TEQ_SEARCH || st.slot != `TEQ_SLOT_SPARE)) begin
            next_st.prev[idx] = st.cur[idx];
            next_st.cur[idx] = multiplexed_analog_in;
        end

        next_st.out_step = (st.mode == TEQ_OFF) ? 1'b1 : st.step_int;
        if (st.mode == TEQ_OFF || st.mode == TEQ_SEARCH) begin
            next_st.out_sync = 1'b1;
        end else begin
            next_st.out_sync = (st.slot == `TEQ_SLOT_SPARE);
        end
        next_st.oe_n = (st.mode == TEQ_OFF) ? `TEQ_ALL_OFF : 9'h000;

        // eye shifter: eight offset-binary bits, msb first
        case (st.eye_st)
            TEQ_EYE_SHIFT: begin
                next_st.eye_ser = st.eye_sh[7];
                next_st.eye_val = 1'b1;
                next_st.eye_sh = {st.eye_sh[6:0], 1'b0};
                next_st.eye_cnt = st.eye_cnt + 3'h1;
                if (st.eye_cnt == 3'h7) begin
                    next_st.eye_st = TEQ_EYE_LAST;
                end
            end
            TEQ_EYE_LAST: begin
                next_st.eye_ser = 1'b0;
                next_st.eye_val = 1'b0;
                next_st.eye_st = TEQ_EYE_IDLE;
            end
            default: begin
                next_st.eye_ser = 1'b0;
                next_st.eye_val = 1'b0;
            end
        endcase
        eye_slot = (st.eye_sel == `TEQ_CHAN_AUX) ? `TEQ_SLOT_AUX : st.eye_sel;
        if (st.mode == TEQ_TEST && fall && st.slot == eye_slot && st.eye_st == TEQ_EYE_IDLE) begin
            next_st.eye_sh = ob;
            next_st.eye_an = ob;
            next_st.eye_cnt = 3'h0;
            next_st.eye_st = TEQ_EYE_SHIFT;
        end
        if (st.mode != TEQ_TEST) begin
            next_st.eye_st = TEQ_EYE_IDLE;
            next_st.eye_ser = 1'b0;
            next_st.eye_val = 1'b0;
            next_st.eye_an = `TEQ_RST_EYE_AN;
        end

        if (st.mode == TEQ_SEARCH) begin
            // envelope: magnitude slice, two agreeing samples
            if (fall) begin
                mag = multiplexed_analog_in[7] ? ~multiplexed_analog_in : multiplexed_analog_in;
                raw = (mag >= `TEQ_ENV_THRESH);
                next_st.env_cand = raw;
                if (raw == st.env_cand) begin
                    next_st.env = raw;
                end
            end
            // qualification counters saturate at the interval
            if (st.env) begin
                next_st.lo_cnt = 16'h0000;
                if (st.hi_cnt != QUAL) begin
                    next_st.hi_cnt = st.hi_cnt + 16'h0001;
                end
            end else begin
                next_st.hi_cnt = 16'h0000;
                if (st.lo_cnt != QUAL) begin
                    next_st.lo_cnt = st.lo_cnt + 16'h0001;
                end
            end
            next_st.env_out = st.env;
            next_st.label = st.env && (st.hi_cnt == QUAL);
            next_st.blank = !st.env && (st.lo_cnt == QUAL);
            if (st.tick_cnt == TICK_LAST) begin
                next_st.tick_cnt = 16'h0000;
                if (st.ticks != `TEQ_TICK_SAT) begin
                    next_st.ticks = st.ticks + 6'h01;
                end else begin
                    next_st.spd = `TEQ_RST_SPEED;
                end
            end else begin
                next_st.tick_cnt = st.tick_cnt + 16'h0001;
            end
            if (next_st.env && !st.env) begin
                next_st.spd = speed_code(st.ticks);
                next_st.ticks = 6'h00;
                next_st.tick_cnt = 16'h0000;
            end
        end else begin
            // parked low outside search; speed reads invalid
            next_st.env_cand = 1'b0;
            next_st.env = 1'b0;
            next_st.env_out = 1'b0;
            next_st.label = 1'b0;
            next_st.blank = 1'b0;
            next_st.hi_cnt = 16'h0000;
            next_st.lo_cnt = 16'h0000;
            next_st.tick_cnt = 16'h0000;
            next_st.ticks = `TEQ_TICK_SAT;
            next_st.spd = `TEQ_RST_SPEED;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
            st.mode <= teq_mode_t'(`TEQ_RST_MODE);
            st.xfer <= `TEQ_RST_XFER;
            st.out_step <= 1'b1;
            st.out_sync <= 1'b1;
            st.oe_n <= `TEQ_ALL_OFF;
            st.eye_an <= `TEQ_RST_EYE_AN;
            st.ticks <= `TEQ_TICK_SAT;
            st.spd <= `TEQ_RST_SPEED;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign mux_step_clock = st.out_step;
    assign mux_frame_sync = st.out_sync;
    assign track_out = st.sliced[7:0];
    assign aux_out = st.sliced[8];
    assign track_oe_n = st.oe_n;
    assign digital_eye_serial = st.eye_ser;
    assign eye_bit_valid = st.eye_val;
    assign analog_eye_out = st.eye_an;
    assign sliced_envelope_out = st.env_out;
    assign label_detect = st.label;
    assign blank_detect = st.blank;

    // checks
    localparam int HALF_MAX = `TEQ_STEP_HALF + 1;
    logic [3:0] a_rises;

    // step rises counted between sync rises, helper for the frame check
    always_ff @(posedge clk) begin
        if (reset || (st.mode != TEQ_NORMAL && st.mode != TEQ_TEST)) begin
            // frame length is unknown until the first sync once the link runs
            a_rises <= 4'hF;
        end else if (mux_step_clock && !$past(mux_step_clock) && mux_frame_sync) begin
            a_rises <= 4'h0;
        end else if (mux_step_clock && !$past(mux_step_clock) && a_rises != 4'hF) begin
            a_rises <= a_rises + 4'h1;
        end
    end

    default clocking a_cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_eye_burst;
        eye_bit_valid [*8] ##1 !eye_bit_valid;
    endsequence

    sequence s_running;
        st.mode == TEQ_NORMAL && $past(st.mode) == TEQ_NORMAL;
    endsequence

    a_off_parks_link: assert property (st.mode == TEQ_OFF |=> mux_step_clock && mux_frame_sync && (&track_oe_n))
        else $error("off mode did not park link and tracks");
    a_search_sync_high: assert property (st.mode == TEQ_SEARCH |=> mux_frame_sync)
        else $error("sync not high in search mode");
    a_step_half_period: assert property ((s_running ##0 $rose(mux_step_clock)) |-> ##[1:HALF_MAX] $fell(mux_step_clock))
        else $error("step clock stuck high too long");
    a_sync_at_step: assert property (($rose(mux_frame_sync) && st.mode == TEQ_NORMAL) |-> $rose(mux_step_clock))
        else $error("sync rose away from a step edge");
    a_frame_ten_slots: assert property ((s_running ##0 $rose(mux_frame_sync) ##0 $past(a_rises) != 4'hF && $past(a_rises) != 4'h0) |-> $past(a_rises) == 4'h9)
        else $error("frame is not ten slots");
    a_search_low_else: assert property (st.mode != TEQ_SEARCH |=> !sliced_envelope_out && !label_detect && !blank_detect)
        else $error("search outputs active outside search");
    a_label_blank_excl: assert property (label_detect |-> !blank_detect && $past(st.hi_cnt) == QUAL)
        else $error("label without qualified envelope");
    a_eye_disabled: assert property (st.mode != TEQ_TEST |=> !digital_eye_serial && !eye_bit_valid && analog_eye_out == 8'hFF)
        else $error("eye outputs active outside test mode");
    // leaving test mode cuts a burst short on purpose, so that case is excluded
    a_eye_eight_bits: assert property (disable iff (reset || st.mode != TEQ_TEST)
        $rose(eye_bit_valid) |-> s_eye_burst)
        else $error("eye burst is not eight bits");
    a_speed_invalid: assert property (st.mode != TEQ_SEARCH |=> st.spd[7])
        else $error("speed flag valid outside search");
    a_speed_read: assert property ((bus.rd && bus.addr == `TEQ_ADDR_SPEED) |=> rdata == $past(st.spd))
        else $error("speed read returned wrong byte");

endmodule

// ===== dv/teq_read_amp.sv
// behavioural read amplifier multiplexer facing the equalizer block
// assumes step and sync come straight from the block's registered outputs
module teq_read_amp (
    // timing from the block
    input wire logic clk,
    input wire logic mux_step_clock,
    input wire logic mux_frame_sync,
    // per channel levels, index 8 is aux
    input wire logic [8:0][7:0] level,
    // sample towards the converter
    output logic [7:0] multiplexed_analog_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] chan = 4'h0;
    logic sync_mid = 1'b0;
    logic [7:0] junk = 8'h5a;
    // sync taken mid slot so the following rise never races its update
    always @(negedge mux_step_clock) sync_mid = mux_frame_sync;
    // next channel on step rise, aux when sync was high
    always @(posedge mux_step_clock) begin
        chan = sync_mid ? 4'h9 : (chan == 4'h9 ? 4'h0 : chan + 4'h1);
    end
    // spare slot carries a value that changes every cycle
    always @(posedge clk) junk <= ~junk;
    assign multiplexed_analog_in = chan < 4'h8 ? level[chan] : (chan == 4'h8 ? junk : level[8]);
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the tape equalizer mode and search block
// assumes the read amplifier model of teq_read_amp.sv on the converter side
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import teq_pkg::*;
    localparam int QUAL = 300;
    localparam int TICK = 16;
    logic clk = 1'b0;
    logic reset = 1'b1;
    teq_bus_req_t bus = '0;
    logic [8:0][7:0] level = '0;
    logic [7:0] rdata, mux_in, track_out, analog_eye_out;
    logic [8:0] track_oe_n;
    logic mux_step_clock, mux_frame_sync, aux_out, digital_eye_serial, eye_bit_valid;
    logic sliced_envelope_out, label_detect, blank_detect;
    logic [2:0] srch;
    logic [31:0] seed = 32'ha2a7_1265;
    int cyc = 0, mismatches = 0, tests_run = 0;
    int step_last = 0, step_per = 0, sync_last = 0, sync_per = 0, sync_hi = 0;
    int half_n = 0, rises = 0;
    assign srch = {blank_detect, label_detect, sliced_envelope_out};

    teq_top #(.QUAL_CYCLES(QUAL), .TICK_CYCLES(TICK)) DUT (
        .clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
        .multiplexed_analog_in(mux_in),
        .mux_step_clock(mux_step_clock), .mux_frame_sync(mux_frame_sync),
        .track_out(track_out), .aux_out(aux_out), .track_oe_n(track_oe_n),
        .digital_eye_serial(digital_eye_serial), .eye_bit_valid(eye_bit_valid),
        .analog_eye_out(analog_eye_out), .sliced_envelope_out(sliced_envelope_out),
        .label_detect(label_detect), .blank_detect(blank_detect)
    );
    teq_read_amp amp (
        .clk(clk), .mux_step_clock(mux_step_clock), .mux_frame_sync(mux_frame_sync),
        .level(level), .multiplexed_analog_in(mux_in)
    );

    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            conclude();
        end
    end
    always @(posedge mux_step_clock) begin
        step_per = cyc - step_last;
        step_last = cyc;
    end
    always @(posedge mux_frame_sync) begin
        sync_per = cyc - sync_last;
        sync_last = cyc;
    end
    always @(negedge mux_frame_sync) sync_hi = cyc - sync_last;
    // aux amplitude alternates every half_n slots to fake a labelled track
    always @(posedge mux_step_clock) begin
        if (half_n > 0) begin
            rises++;
            if (rises >= half_n) begin
                rises = 0;
                level[8] <= (level[8] == 8'h60) ? 8'h04 : 8'h60;
            end
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] code(input int t);
        if (t >= 32) return 8'h80;
        if (t < 4) return {1'b0, 5'(t << 3), 2'h3};
        if (t < 8) return {1'b0, 5'(t << 2), 2'h2};
        if (t < 16) return {1'b0, 5'(t << 1), 2'h1};
        return {1'b0, 5'(t), 2'h0};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= teq_bus_req_t'{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= teq_bus_req_t'{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        d = rdata;
    endtask
    // returns at the first settled cycle where the search output matches
    task automatic wait_for(input int sel, input logic v, input int lim);
        for (int n = 0; n < lim; n++) begin
            @(negedge clk);
            if (srch[sel] === v) break;
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] d;
        logic [8:0] neg;
        int c, n, t0, t;
        int halves[3] = '{2, 4, 6};
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk({mux_step_clock, mux_frame_sync, track_oe_n}, 16'h07ff);
        chk({srch, eye_bit_valid, analog_eye_out}, 16'h00ff);
        rd(2'h1, d);
        chk(d, 8'h80);
        for (c = 0; c < 4; c++) begin
            wr(2'h0, 8'(4 + c));
            rd(2'h0, d);
            chk(d, 8'(4 + c));
        end
        // random signed levels well away from zero, normal then test mode
        // no coefficients to load: the equalizer slices an interpolation of each track's last two samples
        for (c = 0; c < 2; c++) begin
            seed = xs(seed);
            neg = seed[8:0];
            for (n = 0; n < 9; n++) level[n] <= {neg[n], ~neg[n], seed[n + 10 +: 6]};
            wr(2'h0, 8'(4 + c));
            // amplifier resyncs at every sync, aligned from the first one, then two captures per channel
            repeat (1700) @(negedge clk);
            // slicer polarity is left open, so either sense is accepted
            t = ({aux_out, track_out} === neg) || ({aux_out, track_out} === ~neg);
            chk(16'(t), 16'h0001);
            chk(track_oe_n, 16'h0000);
            chk(16'(step_per), 16'd52);
            chk(16'(sync_per), 16'd520);
            chk(16'(sync_hi), 16'd52);
            chk(srch, 3'h0);
        end
        for (c = 0; c < 9; c += 4) begin
            wr(2'h3, 8'(c));
            repeat (600) @(negedge clk);
            for (n = 0; n < 20 && eye_bit_valid === 1'b1; n++) @(negedge clk);
            for (n = 0; n < 700 && eye_bit_valid !== 1'b1; n++) @(negedge clk);
            for (n = 0; n < 8; n++) begin
                d = {d[6:0], digital_eye_serial};
                @(negedge clk);
            end
            chk(d, level[c] ^ 8'h80);
            chk(eye_bit_valid, 1'b0);
            chk(analog_eye_out, level[c] ^ 8'h80);
        end
        wr(2'h0, 8'h04);
        repeat (600) @(negedge clk);
        chk({digital_eye_serial, eye_bit_valid, analog_eye_out}, 16'h00ff);
        level[8] <= 8'h04;
        wr(2'h0, 8'h06);
        @(negedge clk);
        t0 = 0;
        for (n = 0; n < 520; n++) begin
            @(negedge clk);
            t0 += mux_frame_sync;
        end
        chk(16'(t0), 16'd520);
        chk(16'(step_per), 16'd52);
        level[8] <= 8'h60;
        wait_for(0, 1'b1, 400);
        t0 = cyc;
        wait_for(1, 1'b1, QUAL + 400);
        t = (cyc - t0 >= QUAL) && (cyc - t0 <= QUAL + 3);
        chk({15'h0000, t[0], blank_detect}, 16'h0002);
        level[8] <= 8'h04;
        wait_for(0, 1'b0, 400);
        t0 = cyc;
        wait_for(2, 1'b1, QUAL + 400);
        t = (cyc - t0 >= QUAL) && (cyc - t0 <= QUAL + 3);
        chk({15'h0000, t[0], label_detect}, 16'h0002);
        rd(2'h1, d);
        chk(d[7], 1'b1);
        rd(2'h2, d);
        chk(d, 8'h04);
        foreach (halves[i]) begin
            half_n = halves[i];
            repeat (halves[i] * 416) @(negedge clk);
            rd(2'h1, d);
            t = halves[i] * 104 / TICK;
            t0 = (d === code(t - 1)) || (d === code(t)) || (d === code(t + 1));
            chk(16'(t0), 16'h0001);
        end
        half_n = 0;
        level[8] <= 8'h60;
        wait_for(1, 1'b1, QUAL + 600);
        chk(label_detect, 1'b1);
        wr(2'h0, 8'h05);
        repeat (3) @(negedge clk);
        chk(srch, 3'h0);
        wr(2'h0, 8'h07);
        @(negedge clk);
        t0 = 0;
        for (n = 0; n < 120; n++) begin
            @(negedge clk);
            t0 += mux_step_clock & mux_frame_sync;
        end
        chk(16'(t0), 16'd120);
        chk({srch, eye_bit_valid, track_oe_n}, 16'h01ff);
        conclude();
    end
endmodule
